// *** include/host_cfg_pkg.sv ***
// constants, register map, pin roles and escape states of the host port
// configuration block; used by the design, not referenced by its bench
package host_cfg_pkg;
   localparam int NREG = 17;
   localparam int NPIN = 12;
   // register indices on the command port
   localparam logic [4:0] REG_EXT_OPTS = 5'h00;
   localparam logic [4:0] REG_ESC_CHAR = 5'h01;
   localparam logic [4:0] REG_IDLE_TMO = 5'h02;
   localparam logic [4:0] REG_GUARD = 5'h03;
   localparam logic [4:0] REG_PIN_BASE = 5'h04;
   localparam logic [4:0] REG_BUTTON = 5'h10;
   localparam int PIN_BASE = 4;
   // pin numbers; pin p has its role in register PIN_BASE + p
   localparam int PIN_RTS = 0;
   localparam int PIN_CTS = 1;
   localparam int PIN_SOUT = 2;
   localparam int PIN_SIN = 3;
   localparam int PIN_SPI_MISO = 4;
   localparam int PIN_SPI_MOSI = 5;
   localparam int PIN_SPI_SSEL = 6;
   localparam int PIN_SPI_CLK = 7;
   localparam int PIN_SPI_ATTENTION_OUTPUT = 8;
   localparam int PIN_ADC0 = 9;
   localparam int PIN_ADC1 = 10;
   localparam int PIN_ADC2 = 11;
   // role codes
   localparam logic [2:0] ROLE_OFF = 3'h0;
   localparam logic [2:0] ROLE_FUNC = 3'h1;
   localparam logic [2:0] ROLE_ADC = 3'h2;
   localparam logic [2:0] ROLE_DIN = 3'h3;
   localparam logic [2:0] ROLE_LOW = 3'h4;
   localparam logic [2:0] ROLE_HIGH = 3'h5;
   localparam logic [2:0] ROLE_ALT6 = 3'h6;
   localparam logic [2:0] ROLE_ALT7 = 3'h7;
   // reset values; a set bit means the pin starts in its function role
   localparam logic [15:0] RST_EXT_OPTS = 16'h0000;
   localparam logic [15:0] RST_ESC_CHAR = 16'h002b;
   localparam logic [15:0] RST_IDLE_TMO = 16'h0064;
   localparam logic [15:0] RST_GUARD = 16'h03e8;
   localparam logic [11:0] PIN_RST_FUNC = 12'h3fe;
   // value limits and fields
   localparam logic [15:0] GUARD_MIN = 16'h0002;
   localparam logic [15:0] GUARD_MAX = 16'h068d;
   localparam logic [15:0] EXT_MAX = 16'h000a;
   localparam int EXT_STATUS_BIT = 3;
   localparam logic [15:0] BTN_AWAKE = 16'h0001;
   localparam logic [15:0] BTN_NOMINATE = 16'h0002;
   localparam logic [15:0] BTN_RESTORE = 16'h0004;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int MS_NS = 1000000;
   localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
   localparam int IDLE_UNIT_MS = 100;
   localparam int AWAKE_TIME_S = 30;
   localparam logic [14:0] AWAKE_MS = 15'(AWAKE_TIME_S * 1000);
   localparam logic [9:0] FLOW_THRESHOLD = 10'h2f6;
   localparam logic [9:0] FLOW_HYST = 10'h010;

   typedef enum logic [4:0] {
      ST_DATA = 5'h01,
      ST_ESC1 = 5'h02,
      ST_ESC2 = 5'h04,
      ST_ESC3 = 5'h08,
      ST_CMD = 5'h10
   } esc_state_e;

   function automatic logic role_ok(input int pin, input logic [15:0] v);
      logic ok;
      logic [2:0] c;
      ok = 1'b0;
      c = v[2:0];
      if (v[15:3] == 13'h0000) begin
         case (pin)
            PIN_RTS, PIN_SOUT, PIN_SIN: ok = (c != ROLE_ADC) && (c <= ROLE_HIGH);
            PIN_CTS: ok = (c != ROLE_ADC);
            PIN_SPI_MISO, PIN_SPI_MOSI, PIN_SPI_SSEL, PIN_SPI_CLK,
            PIN_SPI_ATTENTION_OUTPUT: ok = (c == ROLE_OFF) || (c == ROLE_FUNC) ||
                               (c == ROLE_LOW) || (c == ROLE_HIGH);
            PIN_ADC0: ok = (c <= ROLE_HIGH);
            PIN_ADC1: ok = (c != ROLE_FUNC) && (c <= ROLE_HIGH);
            PIN_ADC2: ok = (c != ROLE_FUNC) && (c <= ROLE_ALT6);
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   function automatic logic [15:0] reg_default(input int i);
      logic [15:0] r;
      r = 16'h0000;
      case (i)
         0: r = RST_EXT_OPTS;
         1: r = RST_ESC_CHAR;
         2: r = RST_IDLE_TMO;
         3: r = RST_GUARD;
         default: begin
            if (i >= PIN_BASE && i < PIN_BASE + NPIN) begin
               r = PIN_RST_FUNC[i - PIN_BASE] ? 16'h0001 : 16'h0000;
            end
         end
      endcase
      return r;
   endfunction
endpackage

// *** logic/host_port_cfg.sv ***
// host port configuration: escape detection, command mode, pin roles
// assumes rx bytes, command port and status inputs come from logic on clk;
// pin inputs are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - three escape bytes framed by guard silence
// - escape byte any value, resets to plus
// - guard time 2 to max ms, default 1s
// - idle command mode exits silently after timeout
// - exit command leaves now, commits pending settings
// - option bit 3 selects extended status frame
// - rts role codes 0,1,3-5, reset 0
// - cts role adds codes 6,7, reset 1
// - cts codes 6/7 drive rs485 enable polarity
// - serial out role codes 0,1,3-5, reset 1
// - serial in role codes 0,1,3-5, reset 1
// - spi pin roles accept 0,1,4,5 only
// - adc0 role 0-5, code 1 enables button
// - button press 1 awake, 2 nominate, 4 restore
// - adc1 role 0,2-5, reset 0
// - adc2 code 6 shows command mode on pin
// - cts flow stops at threshold, hysteresis release
module host_port_cfg #(
   parameter int MS_CYCLES = host_cfg_pkg::CYC_PER_MS,
   parameter logic [9:0] FLOW_THR = host_cfg_pkg::FLOW_THRESHOLD
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // received bytes from the serial receiver
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic [9:0] rx_fill,
   input wire logic tx_active,
   // parsed command port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [4:0] cmd_idx,
   input wire logic [15:0] cmd_wdata,
   input wire logic exit_command_now,
   output logic cmd_ack,
   output logic cmd_reject,
   output logic [15:0] cmd_rdata,
   // mode and events
   output logic cmd_mode,
   output logic settings_applied,
   input wire logic secure_change,
   output logic status_ext,
   output logic status_plain,
   output logic awake_active,
   output logic nominate,
   output logic restore,
   // pins
   input wire logic [11:0] func_out,
   input wire logic [11:0] func_oe,
   input wire logic [11:0] pin_in,
   output logic [11:0] pin_out,
   output logic [11:0] pin_oe,
   output logic [11:0] dio_in,
   output logic host_rts_ok
);
   host_cfg_pkg::esc_state_e st_q, st_d;
   logic [17:0] ms_cnt_q, ms_cnt_d;
   logic [10:0] silence_q, silence_d, win_q, win_d;
   logic [6:0] sub_q, sub_d;
   logic [15:0] units_q, units_d;
   logic [14:0] awake_q, awake_d;
   logic [15:0] cfg_q [host_cfg_pkg::NREG];
   logic [15:0] cfg_d [host_cfg_pkg::NREG];
   logic [15:0] pend_q [host_cfg_pkg::NREG];
   logic [15:0] pend_d [host_cfg_pkg::NREG];
   logic ack_d, rej_d, commit_d, nom_d, rest_d, press1;
   logic [15:0] rdata_d;
   logic cts_ready_q, cts_ready_d;
   logic [11:0] pin_s1_q, pin_s2_q, btn_prev_q;
   logic [11:0] pout_d, poe_d;
   logic ms_tick, in_cmd, esc_hit, silence_ok, win_late, wr_ok, phys_press;
   logic [10:0] guard;
   logic [7:0] esc;

   assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES - 1));
   assign in_cmd = (st_q == host_cfg_pkg::ST_CMD);
   assign guard = cfg_q[host_cfg_pkg::REG_GUARD][10:0];
   assign esc = cfg_q[host_cfg_pkg::REG_ESC_CHAR][7:0];
   assign esc_hit = rx_valid && (rx_byte == esc);
   assign silence_ok = (silence_q >= guard);
   assign win_late = (win_q >= guard);
   // physical button works only while adc0 holds its function role
   assign phys_press = btn_prev_q[host_cfg_pkg::PIN_ADC0] &&
      !pin_s2_q[host_cfg_pkg::PIN_ADC0] &&
      (cfg_q[host_cfg_pkg::PIN_BASE + host_cfg_pkg::PIN_ADC0][2:0] ==
       host_cfg_pkg::ROLE_FUNC);

   // escape sequence, command mode and timers
   always_comb begin
      st_d = st_q;
      ms_cnt_d = ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
      silence_d = silence_q;
      win_d = win_q;
      sub_d = sub_q;
      units_d = units_q;
      awake_d = awake_q;
      if (rx_valid) begin
         silence_d = 11'h000;
      end else if (ms_tick && silence_q != 11'h7ff) begin
         silence_d = silence_q + 11'h001;
      end
      if (ms_tick && win_q != 11'h7ff) begin
         win_d = win_q + 11'h001;
      end
      if (ms_tick) begin
         if (sub_q == 7'(host_cfg_pkg::IDLE_UNIT_MS - 1)) begin
            sub_d = 7'h00;
            if (units_q != 16'hffff) begin
               units_d = units_q + 16'h0001;
            end
         end else begin
            sub_d = sub_q + 7'h01;
         end
      end
      case (st_q)
         host_cfg_pkg::ST_DATA: begin
            if (esc_hit && silence_ok) begin
               st_d = host_cfg_pkg::ST_ESC1;
               win_d = 11'h000;
            end
         end
         host_cfg_pkg::ST_ESC1, host_cfg_pkg::ST_ESC2: begin
            // all three bytes must land inside one guard window
            if (win_late || (rx_valid && !esc_hit)) begin
               st_d = host_cfg_pkg::ST_DATA;
            end else if (esc_hit) begin
               st_d = (st_q == host_cfg_pkg::ST_ESC1) ?
                  host_cfg_pkg::ST_ESC2 : host_cfg_pkg::ST_ESC3;
            end
         end
         host_cfg_pkg::ST_ESC3: begin
            if (rx_valid) begin
               st_d = host_cfg_pkg::ST_DATA;
            end else if (silence_ok) begin
               st_d = host_cfg_pkg::ST_CMD;
               sub_d = 7'h00;
               units_d = 16'h0000;
            end
         end
         host_cfg_pkg::ST_CMD: begin
            if (exit_command_now) begin
               st_d = host_cfg_pkg::ST_DATA;
            end else if (units_q >= cfg_q[host_cfg_pkg::REG_IDLE_TMO]) begin
               st_d = host_cfg_pkg::ST_DATA;
            end else if (ack_d) begin
               sub_d = 7'h00;
               units_d = 16'h0000;
            end
         end
         default: st_d = host_cfg_pkg::ST_DATA;
      endcase
      if (press1 || phys_press) begin
         awake_d = host_cfg_pkg::AWAKE_MS;
      end else if (ms_tick && awake_q != 15'h0000) begin
         awake_d = awake_q - 15'h0001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= host_cfg_pkg::ST_DATA;
         ms_cnt_q <= 18'h00000;
         silence_q <= 11'h000;
         win_q <= 11'h000;
         sub_q <= 7'h00;
         units_q <= 16'h0000;
         awake_q <= 15'h0000;
      end else begin
         st_q <= st_d;
         ms_cnt_q <= ms_cnt_d;
         silence_q <= silence_d;
         win_q <= win_d;
         sub_q <= sub_d;
         units_q <= units_d;
         awake_q <= awake_d;
      end
   end

   // command port: register writes go to pending copy, exit commits them; a restore press resets both copies at once
   always_comb begin
      pend_d = pend_q;
      cfg_d = cfg_q;
      ack_d = 1'b0;
      rej_d = 1'b0;
      rdata_d = cmd_rdata;
      commit_d = 1'b0;
      nom_d = 1'b0;
      rest_d = 1'b0;
      press1 = 1'b0;
      wr_ok = 1'b0;
      if (cmd_idx == host_cfg_pkg::REG_EXT_OPTS) begin
         wr_ok = (cmd_wdata <= host_cfg_pkg::EXT_MAX);
      end else if (cmd_idx == host_cfg_pkg::REG_ESC_CHAR) begin
         wr_ok = (cmd_wdata[15:8] == 8'h00);
      end else if (cmd_idx == host_cfg_pkg::REG_IDLE_TMO) begin
         wr_ok = (cmd_wdata != 16'h0000);
      end else if (cmd_idx == host_cfg_pkg::REG_GUARD) begin
         wr_ok = (cmd_wdata >= host_cfg_pkg::GUARD_MIN) &&
            (cmd_wdata <= host_cfg_pkg::GUARD_MAX);
      end else if (cmd_idx == host_cfg_pkg::REG_BUTTON) begin
         wr_ok = (cmd_wdata == host_cfg_pkg::BTN_AWAKE) ||
            (cmd_wdata == host_cfg_pkg::BTN_NOMINATE) ||
            (cmd_wdata == host_cfg_pkg::BTN_RESTORE);
      end else if (cmd_idx < host_cfg_pkg::REG_BUTTON) begin
         wr_ok = host_cfg_pkg::role_ok(int'(cmd_idx) - host_cfg_pkg::PIN_BASE,
            cmd_wdata);
      end
      if (cmd_valid) begin
         if (!in_cmd || cmd_idx >= 5'(host_cfg_pkg::NREG)) begin
            rej_d = 1'b1;
         end else if (!cmd_write) begin
            rej_d = (cmd_idx == host_cfg_pkg::REG_BUTTON);
            ack_d = !rej_d;
            if (ack_d) begin
               rdata_d = pend_q[cmd_idx];
            end
         end else if (!wr_ok) begin
            rej_d = 1'b1;
         end else begin
            ack_d = 1'b1;
            if (cmd_idx == host_cfg_pkg::REG_BUTTON) begin
               press1 = (cmd_wdata == host_cfg_pkg::BTN_AWAKE);
               nom_d = (cmd_wdata == host_cfg_pkg::BTN_NOMINATE);
               rest_d = (cmd_wdata == host_cfg_pkg::BTN_RESTORE);
            end else begin
               pend_d[cmd_idx] = cmd_wdata;
            end
         end
      end
      if (in_cmd && exit_command_now) begin
         cfg_d = pend_d;
         commit_d = 1'b1;
      end
      if (rest_d) begin
         for (int i = 0; i < host_cfg_pkg::NREG; i++) begin
            pend_d[i] = host_cfg_pkg::reg_default(i);
            cfg_d[i] = host_cfg_pkg::reg_default(i);
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < host_cfg_pkg::NREG; i++) begin
            cfg_q[i] <= host_cfg_pkg::reg_default(i);
            pend_q[i] <= host_cfg_pkg::reg_default(i);
         end
         cmd_ack <= 1'b0;
         cmd_reject <= 1'b0;
         cmd_rdata <= 16'h0000;
         settings_applied <= 1'b0;
         nominate <= 1'b0;
         restore <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         pend_q <= pend_d;
         cmd_ack <= ack_d;
         cmd_reject <= rej_d;
         cmd_rdata <= rdata_d;
         settings_applied <= commit_d;
         nominate <= nom_d;
         restore <= rest_d;
      end
   end

   // status frames, flow control, awake and mode outputs
   always_comb begin
      cts_ready_d = cts_ready_q;
      if (rx_fill >= FLOW_THR) begin
         cts_ready_d = 1'b0;
      end else if (rx_fill < FLOW_THR - host_cfg_pkg::FLOW_HYST) begin
         cts_ready_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cts_ready_q <= 1'b1;
         status_ext <= 1'b0;
         status_plain <= 1'b0;
         awake_active <= 1'b0;
         cmd_mode <= 1'b0;
      end else begin
         cts_ready_q <= cts_ready_d;
         status_ext <= secure_change &&
            cfg_q[host_cfg_pkg::REG_EXT_OPTS][host_cfg_pkg::EXT_STATUS_BIT];
         status_plain <= secure_change &&
            !cfg_q[host_cfg_pkg::REG_EXT_OPTS][host_cfg_pkg::EXT_STATUS_BIT];
         awake_active <= (awake_d != 15'h0000);
         cmd_mode <= (st_d == host_cfg_pkg::ST_CMD);
      end
   end

   // pin role decode; cts and rts are active low on the wire
   for (genvar p = 0; p < host_cfg_pkg::NPIN; p++) begin : g_pin
      logic [2:0] role;
      assign role = cfg_q[host_cfg_pkg::PIN_BASE + p][2:0];
      always_comb begin
         pout_d[p] = 1'b0;
         poe_d[p] = 1'b0;
         case (role)
            host_cfg_pkg::ROLE_LOW: poe_d[p] = 1'b1;
            host_cfg_pkg::ROLE_HIGH: begin
               pout_d[p] = 1'b1;
               poe_d[p] = 1'b1;
            end
            host_cfg_pkg::ROLE_FUNC: begin
               if (p == host_cfg_pkg::PIN_CTS) begin
                  pout_d[p] = !cts_ready_q;
                  poe_d[p] = 1'b1;
               end else if (p != host_cfg_pkg::PIN_RTS &&
                            p != host_cfg_pkg::PIN_SIN &&
                            p != host_cfg_pkg::PIN_ADC0) begin
                  pout_d[p] = func_out[p];
                  poe_d[p] = func_oe[p];
               end
            end
            host_cfg_pkg::ROLE_ALT6: begin
               if (p == host_cfg_pkg::PIN_CTS) begin
                  pout_d[p] = !tx_active;
                  poe_d[p] = 1'b1;
               end else if (p == host_cfg_pkg::PIN_ADC2) begin
                  pout_d[p] = cmd_mode;
                  poe_d[p] = 1'b1;
               end
            end
            host_cfg_pkg::ROLE_ALT7: begin
               pout_d[p] = tx_active;
               poe_d[p] = 1'b1;
            end
            default: poe_d[p] = 1'b0;
         endcase
      end
      a_role_legal: assert property (@(posedge clk) disable iff (!nrst)
         host_cfg_pkg::role_ok(p, cfg_q[host_cfg_pkg::PIN_BASE + p]))
         else $error("pin role holds an illegal code");
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= 12'h000;
         pin_s2_q <= 12'h000;
         btn_prev_q <= 12'h000;
         pin_out <= 12'h000;
         pin_oe <= 12'h000;
         dio_in <= 12'h000;
         host_rts_ok <= 1'b0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         btn_prev_q <= pin_s2_q;
         pin_out <= pout_d;
         pin_oe <= poe_d;
         dio_in <= pin_s2_q;
         host_rts_ok <= !pin_s2_q[host_cfg_pkg::PIN_RTS] &&
            (cfg_q[host_cfg_pkg::PIN_BASE][2:0] == host_cfg_pkg::ROLE_FUNC);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_escape_entry: assert property ($rose(cmd_mode) |->
      $past(st_q) == host_cfg_pkg::ST_ESC3 && $past(silence_q) >= $past(guard))
      else $error("command mode entered without guarded escape");
   a_esc_store: assert property (cmd_valid && cmd_write && in_cmd &&
      cmd_idx == host_cfg_pkg::REG_ESC_CHAR && cmd_wdata[15:8] == 8'h00 |=>
      cmd_ack && pend_q[host_cfg_pkg::REG_ESC_CHAR] == $past(cmd_wdata))
      else $error("escape byte write not stored");
   a_guard_range: assert property (cmd_ack && $past(cmd_write) &&
      $past(cmd_idx) == host_cfg_pkg::REG_GUARD |->
      $past(cmd_wdata) >= 16'h0002 && $past(cmd_wdata) <= 16'h068d)
      else $error("guard time out of range accepted");
   a_idle_exit: assert property ($fell(cmd_mode) && !settings_applied |->
      $past(units_q) >= $past(cfg_q[host_cfg_pkg::REG_IDLE_TMO]))
      else $error("command mode left before idle timeout");
   a_exit_commit: assert property (cmd_mode && exit_command_now |=>
      !cmd_mode && settings_applied)
      else $error("exit did not leave and commit");
   a_ext_status: assert property (secure_change &&
      cfg_q[host_cfg_pkg::REG_EXT_OPTS][host_cfg_pkg::EXT_STATUS_BIT] |=>
      status_ext && !status_plain)
      else $error("wrong status frame type");
   a_rs485_low: assert property (cfg_q[host_cfg_pkg::PIN_BASE +
      host_cfg_pkg::PIN_CTS][2:0] == host_cfg_pkg::ROLE_ALT6 |=>
      pin_oe[host_cfg_pkg::PIN_CTS] &&
      pin_out[host_cfg_pkg::PIN_CTS] == !$past(tx_active))
      else $error("rs485 enable polarity wrong");
   a_cmd_indicator: assert property (cfg_q[host_cfg_pkg::PIN_BASE +
      host_cfg_pkg::PIN_ADC2][2:0] == host_cfg_pkg::ROLE_ALT6 |=>
      pin_oe[host_cfg_pkg::PIN_ADC2] &&
      pin_out[host_cfg_pkg::PIN_ADC2] == $past(cmd_mode))
      else $error("command indicator pin wrong");
   a_button_awake: assert property (cmd_valid && cmd_write && in_cmd &&
      cmd_idx == host_cfg_pkg::REG_BUTTON && cmd_wdata == 16'h0001 |=>
      awake_active [*8])
      else $error("button press did not hold device awake");
   a_reject_bad: assert property (cmd_valid && cmd_write && in_cmd &&
      cmd_idx == 5'h04 && cmd_wdata == 16'h0002 |=>
      cmd_reject && $stable(pend_q[host_cfg_pkg::PIN_BASE]))
      else $error("illegal rts role accepted");
   a_flow_stop: assert property (rx_fill >= FLOW_THR && cfg_q[5][2:0] ==
      host_cfg_pkg::ROLE_FUNC ##1 cfg_q[5][2:0] == host_cfg_pkg::ROLE_FUNC |=>
      pin_out[host_cfg_pkg::PIN_CTS])
      else $error("cts not deasserted at threshold");
   c_enter_cmd: cover property ($rose(cmd_mode));
   c_commit: cover property (settings_applied);
   c_reject: cover property (cmd_reject);
endmodule

`default_nettype wire

// *** test/host_model.sv ***
// host processor model: sends serial bytes into the port config block
// assumes it shares clk with the bench and alone drives the rx lines
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // serial bytes to the device
   output logic rx_valid,
   output logic [7:0] rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      // stale byte is inverted so nothing can lean on it
      rx_byte <= ~b;
   endtask
   // silence, three escape bytes back to back, silence
   task automatic escape(input logic [7:0] c, input int gap);
      repeat (gap) @(posedge clk);
      repeat (3) send(c);
      repeat (gap) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** test/host_port_pin_and_escape_config_test.sv ***
// bench for the host port config block with a host model on rx
// assumes a short millisecond so guard and idle times stay small
`timescale 1ns/1ps
`default_nettype none
module host_port_pin_and_escape_config_test;
   localparam int MS = 10;
   logic clk, nrst, cmd_valid, cmd_write, exit_command_now, secure_change;
   logic tx_active, rx_valid, cmd_ack, cmd_reject, cmd_mode, settings_applied;
   logic status_ext, status_plain, awake_active, nominate, restore, rts_ok;
   logic [7:0] rx_byte, b;
   logic [9:0] rx_fill;
   logic [4:0] cmd_idx;
   logic [15:0] cmd_wdata, cmd_rdata;
   logic [11:0] func_out, func_oe, pin_in, pin_out, pin_oe, dio_in;
   logic [17:0] notes[$];
   logic [17:0] nt;
   logic [20:0] rj [11] = '{21'h040002, 21'h080002, 21'h080003, 21'h0e0001,
      21'h0f0007, 21'h030001, 21'h03068e, 21'h00000b, 21'h100003,
      21'h010100, 21'h020000};
   logic [20:0] ok [7] = '{21'h050007, 21'h0f0006, 21'h020001, 21'h030002,
      21'h000008, 21'h040005, 21'h0100ff};
   logic [15:0] dflt [16] = '{16'h0, 16'h2b, 16'h64, 16'h3e8, 16'h0, 16'h1,
      16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h0};
   int err_count, n_tests, seed, sa_cnt, ext_cnt, pl_cnt, nom_cnt, rs_cnt, i;

   host_port_cfg #(.MS_CYCLES(MS), .FLOW_THR(10'h2f6)) dut (
      .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_fill(rx_fill), .tx_active(tx_active), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
      .exit_command_now(exit_command_now), .cmd_ack(cmd_ack),
      .cmd_reject(cmd_reject), .cmd_rdata(cmd_rdata), .cmd_mode(cmd_mode),
      .settings_applied(settings_applied), .secure_change(secure_change),
      .status_ext(status_ext), .status_plain(status_plain),
      .awake_active(awake_active), .nominate(nominate), .restore(restore),
      .func_out(func_out), .func_oe(func_oe), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .dio_in(dio_in),
      .host_rts_ok(rts_ok));
   host_model host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));

   task automatic bad(input string m);
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e, string m);
      n_tests++;
      if (g !== e) bad(m);
   endtask
   task automatic chk1(input logic g, input logic e, input string m);
      chk({15'h0, g}, {15'h0, e}, m);
   endtask
   task automatic cmd(input logic w, input logic [4:0] i, logic [15:0] d,
                      input logic rej);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_idx <= i;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      notes.push_back({rej, !w, d});
   endtask
   task automatic pulse_exit();
      @(posedge clk) exit_command_now <= 1'b1;
      @(posedge clk) exit_command_now <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic pulse_sec();
      @(posedge clk) secure_change <= 1'b1;
      @(posedge clk) secure_change <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wait_mode(input logic v, input int n);
      int k;
      k = 0;
      while (cmd_mode !== v && k < n) begin
         @(posedge clk);
         k++;
      end
      chk1(cmd_mode, v, "command mode level");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // answers are paired with the oldest note of the driver
   always @(posedge clk) begin
      if (cmd_ack === 1'b1 || cmd_reject === 1'b1) begin
         if (notes.size() == 0) begin
            bad("answer with no request");
         end else begin
            nt = notes.pop_front();
            chk1(cmd_reject, nt[17], "accept or refuse");
            if (nt[16] && !nt[17]) chk(cmd_rdata, nt[15:0], "read data");
         end
      end
      if (settings_applied === 1'b1) sa_cnt++;
      if (status_ext === 1'b1) ext_cnt++;
      if (status_plain === 1'b1) pl_cnt++;
      if (nominate === 1'b1) nom_cnt++;
      if (restore === 1'b1) rs_cnt++;
   end

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // full run is near 21k cycles; the limit leaves ample margin
   initial begin
      #200000;
      bad("watchdog expired");
      finish_test();
   end
   initial begin
      seed = 98891;
      {nrst, cmd_valid, cmd_write, exit_command_now, secure_change} = 5'h0;
      {cmd_idx, cmd_wdata, rx_fill, tx_active} = 32'h0;
      func_out = 12'($random(seed));
      func_oe = 12'($random(seed));
      pin_in = 12'($random(seed));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk) rx_fill <= 10'h2f6;
      repeat (3) @(posedge clk);
      chk1(pin_out[1], 1'b1, "flow stop at threshold");
      rx_fill <= 10'h2f0;
      repeat (3) @(posedge clk);
      chk1(pin_out[1], 1'b1, "flow hysteresis");
      rx_fill <= 10'h2e5;
      repeat (3) @(posedge clk);
      chk1(pin_out[1], 1'b0, "flow restart");
      pulse_sec();
      chk(pl_cnt[15:0], 16'h1, "plain status");
      repeat (20) begin
         b = 8'($random(seed));
         host.send(b == 8'h2b ? 8'h2a : b);
      end
      chk1(cmd_mode, 1'b0, "stray bytes");
      $display("test done: flow and data mode");
      host.escape(8'h2b, 1002 * MS);
      wait_mode(1'b1, 3 * MS);
      for (i = 0; i < 16; i++) cmd(1'b0, i[4:0], dflt[i], 1'b0);
      for (i = 0; i < 11; i++) cmd(1'b1, rj[i][20:16], rj[i][15:0], 1'b1);
      cmd(1'b0, 5'h10, 16'h0, 1'b1);
      cmd(1'b0, 5'h04, 16'h0, 1'b0);
      for (i = 0; i < 7; i++) cmd(1'b1, ok[i][20:16], ok[i][15:0], 1'b0);
      cmd(1'b1, 5'h10, 16'h2, 1'b0);
      cmd(1'b1, 5'h10, 16'h1, 1'b0);
      repeat (4) @(posedge clk);
      chk(nom_cnt[15:0], 16'h1, "nominate");
      chk1(awake_active, 1'b1, "stay awake");
      chk1(pin_out[0], 1'b0, "pending role not active");
      $display("test done: registers");
      pulse_exit();
      chk1(cmd_mode, 1'b0, "exit now");
      chk(sa_cnt[15:0], 16'h1, "commit on exit");
      chk1(pin_out[0] & pin_oe[0], 1'b1, "rts driven high");
      chk1(pin_out[11] | !pin_oe[11], 1'b0, "indicator low");
      chk1(pin_out[1], 1'b0, "idle enable low");
      tx_active <= 1'b1;
      repeat (3) @(posedge clk);
      chk1(pin_out[1], 1'b1, "transmit enable high");
      pulse_sec();
      chk(ext_cnt[15:0], 16'h1, "extended status");
      host.escape(8'hff, 4 * MS);
      wait_mode(1'b1, 3 * MS);
      repeat (2) @(posedge clk);
      chk1(pin_out[11], 1'b1, "indicator high");
      repeat (80 * MS) @(posedge clk);
      chk1(cmd_mode, 1'b1, "early idle exit");
      wait_mode(1'b0, 40 * MS);
      chk(sa_cnt[15:0], 16'h1, "silent exit");
      $display("test done: exit and timeout");
      host.escape(8'hff, 4 * MS);
      wait_mode(1'b1, 3 * MS);
      cmd(1'b1, 5'h10, 16'h4, 1'b0);
      cmd(1'b0, 5'h03, 16'h03e8, 1'b0);
      cmd(1'b0, 5'h01, 16'h002b, 1'b0);
      cmd(1'b1, 5'h05, 16'h0006, 1'b0);
      cmd(1'b1, 5'h04, 16'h0001, 1'b0);
      pulse_exit();
      chk(rs_cnt[15:0], 16'h1, "restore pulse");
      chk1(pin_out[1] | !pin_oe[1], 1'b0, "rs485 low on tx");
      chk1(rts_ok, !pin_in[0], "rts flow input");
      chk({4'h0, dio_in}, {4'h0, pin_in}, "pin inputs");
      tx_active <= 1'b0;
      repeat (3) @(posedge clk);
      chk1(pin_out[1], 1'b1, "rs485 high when idle");
      repeat (4) @(posedge clk);
      chk(16'(notes.size()), 16'h0, "answers missing");
      $display("test done: restore");
      finish_test();
   end
endmodule
`default_nettype wire
